// ===== qre_cfg.svh
// Constants shared by both ends of the quad I/O read engine
`ifndef QRE_CFG_SVH
`define QRE_CFG_SVH
`define QRE_CMD_FQIO    8'hEB
`define QRE_CMD_WQIO    8'hE7
`define QRE_CMD_OWQIO   8'hE3
`define QRE_DUMMY_FQIO  3'h4
`define QRE_DUMMY_WQIO  3'h2
`define QRE_DUMMY_OWQIO 3'h0
`define QRE_INSTR_LAST  3'h7
`define QRE_ADDR_LAST   3'h5
`define QRE_MODE_LAST   3'h1
`define QRE_RST_LAST    3'h7
`define QRE_CONT_PAIR   2'h2
`define QRE_WRAP_RESET  3'h1
`define QRE_WRAP_DIS    0
`define QRE_SEC_MASK    8'h07
`define QRE_ALL_ONES    4'hF
`define QRE_MEM_AW      19
`define QRE_SCK_HALF    8'h02
`endif

// ===== qre_pkg.sv
// Types and helpers shared by both ends of the quad I/O read engine
`include "qre_cfg.svh"
package qre_pkg;
  typedef enum logic [6:0] {
    D_IDLE   = 7'b000_0001,
    D_INSTR  = 7'b000_0010,
    D_ADDR   = 7'b000_0100,
    D_MODE   = 7'b000_1000,
    D_DUMMY  = 7'b001_0000,
    D_DATA   = 7'b010_0000,
    D_IGNORE = 7'b100_0000
  } qre_dev_state_t;
  typedef enum logic [8:0] {
    H_IDLE  = 9'b0_0000_0001,
    H_INSTR = 9'b0_0000_0010,
    H_ADDR  = 9'b0_0000_0100,
    H_MODE  = 9'b0_0000_1000,
    H_DUMMY = 9'b0_0001_0000,
    H_DATA  = 9'b0_0010_0000,
    H_FF    = 9'b0_0100_0000,
    H_END   = 9'b0_1000_0000,
    H_GAP   = 9'b1_0000_0000
  } qre_host_state_t;
  // Dummy clocks that follow the mode byte for each read command
  function automatic logic [2:0] qre_dummy(input logic [7:0] cmd);
    if (cmd == `QRE_CMD_WQIO) begin
      return `QRE_DUMMY_WQIO;
    end else if (cmd == `QRE_CMD_OWQIO) begin
      return `QRE_DUMMY_OWQIO;
    end
    return `QRE_DUMMY_FQIO;
  endfunction
endpackage

// ===== qre_if.sv
// Serial link between host controller and flash read engine
`timescale 1ns/1ns
interface qre_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  wire  [3:0] io;
  // Wire level: host drive, else device drive, else pull-up
  assign io = (host_io_oe & host_io_out) | (~host_io_oe & dev_io_oe & dev_io_out) | (~host_io_oe & ~dev_io_oe);
  modport host (output cs_n, output sck, output host_io_out, output host_io_oe, input io);
  modport device (input cs_n, input sck, output dev_io_out, output dev_io_oe, input io);
endinterface

// ===== qre_wrap_addr.sv
// Next read address with optional wrap inside an aligned section
`timescale 1ns/1ns
`include "qre_cfg.svh"
module qre_wrap_addr (
  input  wire logic [23:0] addr,
  input  wire logic        wrap_on,
  input  wire logic [1:0]  wrap_len,
  output wire logic [23:0] next_addr
);
  // Ones below the section length, so 16 bytes gives a mask of four low bits
  wire [7:0]  mask = ~(~(`QRE_SEC_MASK) << wrap_len);
  wire [23:0] inc  = addr + 24'h00_0001;
  wire [7:0]  wrapped = (addr[7:0] & ~mask) | (inc[7:0] & mask);
  // Section of 8 to 64 bytes stays within the page; else linear
  assign next_addr = wrap_on ? {addr[23:8], wrapped} : inc;
endmodule

// ===== qre_device.sv
// Flash end: quad I/O read decode, continuous mode, wrap, data out
`timescale 1ns/1ns
`include "qre_cfg.svh"
module qre_device #(
  parameter int MEM_AW = `QRE_MEM_AW
) (
  input  wire logic              CLOCK,
  input  wire logic              RSTN,
  qre_if.device                  link,
  input  wire logic              QUAD_ENABLE,
  input  wire logic              WRAP_WE,
  input  wire logic [2:0]        WRAP_BITS,
  input  wire logic              LOAD_WE,
  input  wire logic [MEM_AW-1:0] LOAD_ADDR,
  input  wire logic [7:0]        LOAD_DATA,
  output wire logic              CONT_ACTIVE,
  output wire logic [7:0]        CONT_CMD,
  output wire logic [2:0]        WRAP_SETTING,
  output wire logic              BUSY
);
  qre_pkg::qre_dev_state_t state;
  logic [7:0]  mem [0:(1<<MEM_AW)-1];
  logic        sck_q;
  logic [7:0]  instr;
  logic [7:0]  cmd;
  logic [7:0]  cont_cmd;
  logic        cont;
  logic [23:0] addr;
  logic [3:0]  mode_hi;
  logic [2:0]  cnt;
  logic [2:0]  wrap_set;
  logic        nib_lo;
  logic [7:0]  data_byte;
  logic [3:0]  io_out;
  logic        io_oe;

  // Edge detection of the serial clock
  wire         sck_rise   = link.sck & ~sck_q;
  wire         sck_fall   = ~link.sck & sck_q;
  wire [3:0]   nib        = link.io;
  wire [7:0]   instr_full = {instr[6:0], link.io[0]};

  // Instruction decode and per-command timing
  wire         is_fqio    = instr_full == `QRE_CMD_FQIO;
  wire         is_wqio    = instr_full == `QRE_CMD_WQIO;
  wire         is_owqio   = instr_full == `QRE_CMD_OWQIO;
  wire         accept     = (is_fqio | is_wqio | is_owqio) & QUAD_ENABLE;
  wire [2:0]   dummy      = qre_pkg::qre_dummy(cmd);
  wire         dummy_end  = cnt == dummy - 3'h1;
  wire         instr_end  = cnt == `QRE_INSTR_LAST;
  wire         addr_end   = cnt == `QRE_ADDR_LAST;
  wire         mode_end   = cnt == `QRE_MODE_LAST;

  // Only select pair counts; bits 7-6 and the low nibble are ignored
  wire         mode_cont  = mode_hi[1:0] == `QRE_CONT_PAIR;

  // Wrap applies to fast quad and word quad reads only
  wire         wrap_on    = ~wrap_set[`QRE_WRAP_DIS] & (cmd != `QRE_CMD_OWQIO);
  wire [23:0]  addr_next;
  wire [7:0]   mem_byte   = mem[addr[MEM_AW-1:0]];

  qre_wrap_addr u_wrap (
    .addr      (addr),
    .wrap_on   (wrap_on),
    .wrap_len  (wrap_set[2:1]),
    .next_addr (addr_next)
  );

  // Status and link outputs
  assign CONT_ACTIVE     = cont;
  assign CONT_CMD        = cont_cmd;
  assign WRAP_SETTING    = wrap_set;
  assign BUSY            = state != qre_pkg::D_IDLE;
  assign link.dev_io_out = io_out;
  assign link.dev_io_oe  = {4{io_oe}};

  // Serial clock history
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= link.sck;
    end
  end

  // Wrap setting register, wrap disabled after reset
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      wrap_set <= `QRE_WRAP_RESET;
    end else if (WRAP_WE) begin
      wrap_set <= WRAP_BITS;
    end
  end

  // Array preload from the user side
  always_ff @(posedge CLOCK) begin
    if (LOAD_WE) begin
      mem[LOAD_ADDR] <= LOAD_DATA;
    end
  end

  // Continuous read state, kept while chip select is high
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cont     <= 1'b0;
      cont_cmd <= `QRE_CMD_FQIO;
    end else if (!link.cs_n && state == qre_pkg::D_MODE && sck_rise && mode_end) begin
      cont     <= mode_cont;
      cont_cmd <= cmd;
    end
  end

  // Command sequencer: instruction, address, mode, dummies
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state   <= qre_pkg::D_IDLE;
      cnt     <= 3'h0;
      instr   <= 8'h00;
      cmd     <= `QRE_CMD_FQIO;
      addr    <= 24'h00_0000;
      mode_hi <= 4'h0;
    end else if (link.cs_n) begin
      state   <= qre_pkg::D_IDLE;
      cnt     <= 3'h0;
      instr   <= 8'h00;
    end else begin
      case (state)
        qre_pkg::D_IDLE: begin
          cnt <= 3'h0;
          if (cont) begin
            cmd   <= cont_cmd;
            state <= qre_pkg::D_ADDR;
          end else begin
            state <= qre_pkg::D_INSTR;
          end
        end
        qre_pkg::D_INSTR: begin
          if (sck_rise) begin
            instr <= instr_full;
            cnt   <= cnt + 3'h1;
            if (instr_end) begin
              cnt   <= 3'h0;
              cmd   <= instr_full;
              state <= accept ? qre_pkg::D_ADDR : qre_pkg::D_IGNORE;
            end
          end
        end
        qre_pkg::D_ADDR: begin
          if (sck_rise) begin
            addr <= {addr[19:0], nib};
            cnt  <= cnt + 3'h1;
            if (addr_end) begin
              cnt   <= 3'h0;
              state <= qre_pkg::D_MODE;
            end
          end
        end
        qre_pkg::D_MODE: begin
          if (sck_rise) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h0) begin
              mode_hi <= nib;
            end
            if (mode_end) begin
              cnt   <= 3'h0;
              state <= (dummy == 3'h0) ? qre_pkg::D_DATA : qre_pkg::D_DUMMY;
            end
          end
        end
        qre_pkg::D_DUMMY: begin
          if (sck_rise) begin
            cnt <= cnt + 3'h1;
            if (dummy_end) begin
              cnt   <= 3'h0;
              state <= qre_pkg::D_DATA;
            end
          end
        end
        qre_pkg::D_DATA: begin
          if (sck_fall && nib_lo) begin
            addr <= addr_next;
          end
        end
        default: begin
          state <= qre_pkg::D_IGNORE;
        end
      endcase
    end
  end

  // Data nibbles on falling edges, high nibble first, for as long as selected
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      io_out    <= 4'h0;
      io_oe     <= 1'b0;
      nib_lo    <= 1'b0;
      data_byte <= 8'h00;
    end else if (link.cs_n || state != qre_pkg::D_DATA) begin
      io_oe  <= 1'b0;
      nib_lo <= 1'b0;
    end else if (sck_fall) begin
      io_oe <= 1'b1;
      if (!nib_lo) begin
        io_out    <= mem_byte[7:4];
        data_byte <= mem_byte;
        nib_lo    <= 1'b1;
      end else begin
        io_out <= data_byte[3:0];
        nib_lo <= 1'b0;
      end
    end
  end
endmodule

// ===== qre_host.sv
// Host end: issues quad I/O reads and continuous mode reset over the link
`timescale 1ns/1ns
`include "qre_cfg.svh"
module qre_host #(
  parameter logic [7:0] SCK_HALF = `QRE_SCK_HALF
) (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  qre_if.host              link,
  input  wire logic        START,
  input  wire logic        RST_CONT,
  input  wire logic [7:0]  CMD,
  input  wire logic [23:0] ADDR,
  input  wire logic [7:0]  MODE,
  input  wire logic [15:0] NBYTES,
  output logic      [7:0]  RD_DATA,
  output logic             RD_VALID,
  output wire logic        BUSY,
  output wire logic        CONT_ACTIVE
);
  qre_pkg::qre_host_state_t state;
  logic [7:0]  div;
  logic        sck;
  logic        cs_n;
  logic [3:0]  out;
  logic [3:0]  oe;
  logic [7:0]  ins;
  logic [31:0] sh;
  logic [7:0]  cmd_q;
  logic [1:0]  pair_q;
  logic [2:0]  cnt;
  logic [15:0] left;
  logic [3:0]  hi_nib;
  logic        nib_lo;
  logic        cont;
  logic [7:0]  cont_cmd;

  // Clock divider and edge strobes
  wire        idle     = state == qre_pkg::H_IDLE;
  wire        tick     = ~idle & (div == SCK_HALF - 8'h01);
  wire        run      = state != qre_pkg::H_GAP;
  wire        rise     = tick & run & ~sck;
  wire        fall     = tick & run & sck;
  wire [2:0]  dummy    = qre_pkg::qre_dummy(cmd_q);
  wire [7:0]  cmd_sel  = cont ? cont_cmd : CMD;

  assign link.cs_n        = cs_n;
  assign link.sck         = sck;
  assign link.host_io_out = out;
  assign link.host_io_oe  = oe;
  assign BUSY             = ~idle;
  assign CONT_ACTIVE      = cont;

  // Divider runs only while a command is in progress
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      div <= 8'h00;
      sck <= 1'b0;
    end else begin
      div <= (idle | tick) ? 8'h00 : div + 8'h01;
      sck <= (tick & run) ? ~sck : (idle ? 1'b0 : sck);
    end
  end

  // Command sequencer
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state    <= qre_pkg::H_IDLE;
      cs_n     <= 1'b1;
      out      <= 4'h0;
      oe       <= 4'h0;
      ins      <= 8'h00;
      sh       <= 32'h0000_0000;
      cmd_q    <= `QRE_CMD_FQIO;
      pair_q   <= 2'h0;
      cnt      <= 3'h0;
      left     <= 16'h0000;
      hi_nib   <= 4'h0;
      nib_lo   <= 1'b0;
      cont     <= 1'b0;
      cont_cmd <= `QRE_CMD_FQIO;
      RD_DATA  <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      case (state)
        qre_pkg::H_IDLE: begin
          cnt    <= 3'h0;
          nib_lo <= 1'b0;
          if (RST_CONT) begin
            cs_n  <= 1'b0;
            out   <= `QRE_ALL_ONES;
            oe    <= `QRE_ALL_ONES;
            state <= qre_pkg::H_FF;
          end else if (START) begin
            cs_n   <= 1'b0;
            cmd_q  <= cmd_sel;
            ins    <= CMD;
            sh     <= {ADDR, MODE};
            pair_q <= MODE[5:4];
            left   <= NBYTES;
            if (cont) begin
              out   <= ADDR[23:20];
              oe    <= `QRE_ALL_ONES;
              state <= qre_pkg::H_ADDR;
            end else begin
              out   <= {3'h0, CMD[7]};
              oe    <= 4'h1;
              state <= qre_pkg::H_INSTR;
            end
          end
        end
        qre_pkg::H_INSTR: begin
          if (rise) begin
            ins <= {ins[6:0], 1'b0};
            cnt <= cnt + 3'h1;
            if (cnt == `QRE_INSTR_LAST) begin
              cnt   <= 3'h0;
              state <= qre_pkg::H_ADDR;
            end
          end else if (fall) begin
            out <= {3'h0, ins[7]};
          end
        end
        qre_pkg::H_ADDR, qre_pkg::H_MODE: begin
          if (rise) begin
            sh  <= {sh[27:0], 4'h0};
            cnt <= cnt + 3'h1;
            if (state == qre_pkg::H_ADDR && cnt == `QRE_ADDR_LAST) begin
              cnt   <= 3'h0;
              state <= qre_pkg::H_MODE;
            end else if (state == qre_pkg::H_MODE && cnt == `QRE_MODE_LAST) begin
              cnt      <= 3'h0;
              oe       <= 4'h0;
              cont     <= pair_q == `QRE_CONT_PAIR;
              cont_cmd <= cmd_q;
              state    <= (dummy == 3'h0) ? qre_pkg::H_DATA : qre_pkg::H_DUMMY;
            end
          end else if (fall) begin
            out <= sh[31:28];
            oe  <= `QRE_ALL_ONES;
          end
        end
        qre_pkg::H_DUMMY: begin
          if (rise) begin
            cnt <= cnt + 3'h1;
            if (cnt == dummy - 3'h1) begin
              cnt   <= 3'h0;
              state <= qre_pkg::H_DATA;
            end
          end
        end
        qre_pkg::H_DATA: begin
          if (rise) begin
            nib_lo <= ~nib_lo;
            hi_nib <= link.io;
            if (nib_lo) begin
              RD_DATA  <= {hi_nib, link.io};
              RD_VALID <= 1'b1;
              left     <= left - 16'h0001;
              if (left == 16'h0001) begin
                state <= qre_pkg::H_END;
              end
            end
          end
        end
        qre_pkg::H_FF: begin
          if (rise) begin
            cnt <= cnt + 3'h1;
            if (cnt == `QRE_RST_LAST) begin
              cont  <= 1'b0;
              state <= qre_pkg::H_END;
            end
          end
        end
        qre_pkg::H_END: begin
          if (tick) begin
            cs_n  <= 1'b1;
            oe    <= 4'h0;
            state <= qre_pkg::H_GAP;
          end
        end
        default: begin
          if (tick) begin
            state <= qre_pkg::H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ===== qre_link_props.sv
// Concurrent checks on the serial link between the host and flash ends
`timescale 1ns/1ns
module qre_link_props (
  input wire logic       CLOCK,
  input wire logic       RSTN,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  // Steps of a frame as seen on the sampled link
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_fell_one_ago;
    $past(sck, 2) && !$past(sck);
  endsequence
  sequence s_fell_two_ago;
    $past(sck, 3) && !$past(sck, 2);
  endsequence
  sequence s_dev_takes_bus;
    $rose(dev_io_oe[0]);
  endsequence
  // Both ends never drive the lines at once
  a_no_line_fight: assert property (!(|host_io_oe && |dev_io_oe))
    else $error("host and flash drive the lines together");
  a_host_lanes: assert property (host_io_oe inside {4'h0, 4'h1, 4'hF})
    else $error("host enables an odd set of lines");
  a_dev_lanes: assert property (dev_io_oe inside {4'h0, 4'hF})
    else $error("flash enables only part of the lines");
  a_release_first: assert property (s_dev_takes_bus |-> host_io_oe == 4'h0 && $past(host_io_oe) == 4'h0)
    else $error("flash took the lines before the host let go");
  a_end_drops: assert property (s_frame_end |-> ##[1:2] dev_io_oe == 4'h0)
    else $error("flash still drives after chip select rose");
  a_idle_quiet: assert property (cs_n && $past(cs_n, 3) |-> dev_io_oe == 4'h0)
    else $error("flash drives while deselected");
  a_idle_sck_low: assert property (cs_n |-> !sck)
    else $error("serial clock high outside a frame");
  a_sck_holds: assert property ($changed(sck) |=> $stable(sck))
    else $error("serial clock half period shorter than two cycles");
  a_data_on_fall: assert property (
    $changed(dev_io_out) && dev_io_oe == 4'hF && $past(dev_io_oe) == 4'hF && !cs_n && !$past(cs_n)
    |-> s_fell_one_ago or s_fell_two_ago)
    else $error("flash data changed away from a falling serial clock");
  a_flash_on_lines: assert property (dev_io_oe == 4'hF && host_io_oe == 4'h0 |-> io == dev_io_out)
    else $error("lines do not show the flash data");
endmodule

// ===== quad_io_read_engine_tb.sv
// Self-checking bench for the host and flash ends joined over the link
`timescale 1ns/1ns
`include "qre_cfg.svh"
module quad_io_read_engine_tb;
  logic        clock;
  logic        rstn;
  logic        start;
  logic        rst_cont;
  logic [7:0]  cmd;
  logic [23:0] addr;
  logic [7:0]  mode;
  logic [15:0] nbytes;
  logic        quad_en;
  logic        wrap_we;
  logic [2:0]  wrap_bits;
  logic [2:0]  wrap_cur;
  logic        load_we;
  logic [9:0]  load_addr;
  logic [7:0]  load_data;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        h_busy;
  logic        h_cont;
  logic        d_cont;
  logic [7:0]  d_cmd;
  logic [2:0]  d_wrap;
  logic        d_busy;
  int          num_errors;
  int          n_compared;
  int          lat;
  int          lat_full;
  qre_if qre_if_inst ();
  // Both ends and the link checker
  qre_host qre_host_inst (.CLOCK(clock), .RSTN(rstn), .link(qre_if_inst.host), .START(start), .RST_CONT(rst_cont),
    .CMD(cmd), .ADDR(addr), .MODE(mode), .NBYTES(nbytes), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .BUSY(h_busy), .CONT_ACTIVE(h_cont));
  qre_device #(.MEM_AW(10)) qre_device_inst (.CLOCK(clock), .RSTN(rstn), .link(qre_if_inst.device),
    .QUAD_ENABLE(quad_en), .WRAP_WE(wrap_we), .WRAP_BITS(wrap_bits), .LOAD_WE(load_we), .LOAD_ADDR(load_addr),
    .LOAD_DATA(load_data), .CONT_ACTIVE(d_cont), .CONT_CMD(d_cmd), .WRAP_SETTING(d_wrap), .BUSY(d_busy));
  qre_link_props qre_link_props_inst (.CLOCK(clock), .RSTN(rstn), .cs_n(qre_if_inst.cs_n), .sck(qre_if_inst.sck),
    .host_io_out(qre_if_inst.host_io_out), .host_io_oe(qre_if_inst.host_io_oe),
    .dev_io_out(qre_if_inst.dev_io_out), .dev_io_oe(qre_if_inst.dev_io_oe), .io(qre_if_inst.io));
  // Clock at 250 MHz
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Array contents, a function of the address
  function automatic logic [7:0] pat(input logic [9:0] a);
    return a[7:0] ^ {6'h2D, a[9:8]};
  endfunction
  // Following address: wrap inside the section, or plain increment
  function automatic logic [23:0] next_exp(input logic [23:0] a, input logic [7:0] c);
    logic [23:0] msk;
    msk = (24'h00_0008 << wrap_cur[2:1]) - 24'h00_0001;
    if (wrap_cur[0] == 1'b0 && c != `QRE_CMD_OWQIO) begin
      return (a & ~msk) | ((a + 24'h00_0001) & msk);
    end
    return a + 24'h00_0001;
  endfunction
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic time_out();
    num_errors++;
    $display("BAD wait expected done seen timeout");
    complete_run();
  endtask
  task automatic wait_idle();
    int t;
    t = 0;
    while (h_busy !== 1'b0 && t < 1000) begin
      @(posedge clock);
      t++;
    end
    if (t >= 1000) begin
      time_out();
    end
  endtask
  // One read; checks every byte and returns cycles to the first byte
  task automatic do_read(input logic [7:0] c, input logic [23:0] a, input logic [7:0] m, input int n,
                         input logic ff, output int lat_o);
    logic [23:0] cur;
    int          got;
    int          t;
    cur = a;
    got = 0;
    t = 0;
    lat_o = 0;
    cmd <= c;
    addr <= a;
    mode <= m;
    nbytes <= n[15:0];
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    while (got < n && t < 5000) begin
      @(posedge clock);
      t++;
      if (rd_valid === 1'b1) begin
        if (got == 0) begin
          lat_o = t;
          check("flash busy", 24'h00_0001, {23'h00_0000, d_busy});
        end
        check("read data", ff ? 24'h00_00FF : {16'h0000, pat(cur[9:0])}, {16'h0000, rd_data});
        cur = next_exp(cur, c);
        got++;
      end
    end
    if (t >= 5000) begin
      time_out();
    end
    wait_idle();
    check("flash idle", 24'h00_0000, {23'h00_0000, d_busy});
  endtask
  task automatic set_wrap(input logic [2:0] w);
    wrap_we <= 1'b1;
    wrap_bits <= w;
    wrap_cur = w;
    @(posedge clock);
    wrap_we <= 1'b0;
    @(posedge clock);
    check("wrap setting", {21'h00_0000, w}, {21'h00_0000, d_wrap});
  endtask
  task automatic send_reset();
    rst_cont <= 1'b1;
    @(posedge clock);
    rst_cont <= 1'b0;
    @(posedge clock);
    wait_idle();
  endtask
  // Reset state, then the three commands with their dummy counts
  task automatic plain_reads();
    check("wrap at reset", 24'h00_0001, {21'h00_0000, d_wrap});
    check("cont at reset", 24'h00_0000, {22'h00_0000, d_cont, h_cont});
    do_read(8'hEB, 24'h00_00FE, 8'h00, 5, 1'b0, lat_full);
    do_read(8'hE7, 24'h00_0132, 8'hF0, 3, 1'b0, lat);
    check("word read latency", 24'(lat_full - 8), 24'(lat));
    do_read(8'hE3, 24'h00_0240, 8'h0F, 3, 1'b0, lat);
    check("octal read latency", 24'(lat_full - 16), 24'(lat));
  endtask
  // Continuous mode per command: enter, reuse, leave
  task automatic cont_modes();
    logic [7:0] c;
    int         lc;
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 8'hEB : (i == 1) ? 8'hE7 : 8'hE3;
      do_read(c, 24'h00_0310, 8'h6F, 2, 1'b0, lc);
      check("cont entered", 24'h00_0001, {23'h00_0000, d_cont});
      check("cont command", {16'h0000, c}, {16'h0000, d_cmd});
      repeat (20) @(posedge clock);
      do_read(8'h0B, 24'h00_0320, 8'hA0, 2, 1'b0, lat);
      check("cont latency", 24'(lc - 32), 24'(lat));
      if (i == 0) begin
        do_read(8'h0B, 24'h00_0330, 8'h30, 1, 1'b0, lat);
      end else begin
        send_reset();
      end
      check("cont left", 24'h00_0000, {22'h00_0000, d_cont, h_cont});
      do_read(c, 24'h00_0340, 8'h00, 1, 1'b0, lat);
      check("full latency", 24'(lc), 24'(lat));
    end
  endtask
  // Every wrap length, word read wrap, octal unwrapped, then wrap off
  task automatic wrap_reads();
    for (int l = 0; l < 4; l++) begin
      set_wrap({l[1:0], 1'b0});
      do_read(8'hEB, 24'h00_041D, 8'h00, (8 << l) + 3, 1'b0, lat);
    end
    do_read(8'hE7, 24'h00_047A, 8'h00, 20, 1'b0, lat);
    do_read(8'hE3, 24'h00_04F0, 8'h00, 20, 1'b0, lat);
    set_wrap(3'b001);
    do_read(8'hEB, 24'h00_05FC, 8'h00, 8, 1'b0, lat);
  endtask
  // Quad enable clear and an unknown command leave the lines pulled up
  task automatic refusals();
    quad_en <= 1'b0;
    do_read(8'hEB, 24'h00_0010, 8'h00, 2, 1'b1, lat);
    quad_en <= 1'b1;
    do_read(8'h0B, 24'h00_0010, 8'h00, 2, 1'b1, lat);
    do_read(8'hE7, 24'h00_0010, 8'h00, 2, 1'b0, lat);
  endtask
  initial begin
    num_errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    start = 1'b0;
    rst_cont = 1'b0;
    cmd = 8'h00;
    addr = 24'h00_0000;
    mode = 8'h00;
    nbytes = 16'h0001;
    quad_en = 1'b1;
    wrap_we = 1'b0;
    wrap_bits = 3'b001;
    wrap_cur = 3'b001;
    load_we = 1'b0;
    load_addr = 10'h000;
    load_data = 8'h00;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int a = 0; a < 1024; a++) begin
      load_we <= 1'b1;
      load_addr <= a[9:0];
      load_data <= pat(a[9:0]);
      @(posedge clock);
    end
    load_we <= 1'b0;
    @(posedge clock);
    plain_reads();
    cont_modes();
    wrap_reads();
    refusals();
    complete_run();
  end
endmodule
